// *** core/dbca_map.svh ***
// Named offsets, field positions, reset values and counts for the burst column access block.
`ifndef DBCA_MAP_SVH
`define DBCA_MAP_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DBCA_OFS_MODE 8'h00
`define DBCA_OFS_EMR 8'h04
`define DBCA_OFS_STAT 8'h08
// ----------------------------------------
// Field positions and codes
// ----------------------------------------
`define DBCA_BL_MSB 2
`define DBCA_BL_LSB 0
`define DBCA_BT_BIT 3
`define DBCA_CL_MSB 6
`define DBCA_CL_LSB 4
`define DBCA_AL_MSB 5
`define DBCA_AL_LSB 3
`define DBCA_A10_BIT 10
`define DBCA_BL4_CODE 3'h2
`define DBCA_BL8_CODE 3'h3
`define DBCA_BA_MR 2'h0
`define DBCA_BA_EMR 2'h1
`define DBCA_STAT_PAD 25'h0
// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define DBCA_MODE_RST 8'h32
`define DBCA_EMR_RST 8'h00
`define DBCA_PIN_RST 39'h7F_FFFF_FFFB
`define DBCA_HALF_BL4 4'h2
`define DBCA_HALF_BL8 4'h4
`define DBCA_LAST_BL4 3'h3
`define DBCA_LAST_BL8 3'h7
`define DBCA_RESP_OKAY 2'h0
`define DBCA_RESP_SLVERR 2'h2
`endif

// *** core/dbca_pkg.sv ***
// Types shared by the burst column access block.
package dbca_pkg;
	typedef enum logic [5:0] {
		DBCA_NOP = 6'h01,
		DBCA_ACT = 6'h02,
		DBCA_RD = 6'h04,
		DBCA_WR = 6'h08,
		DBCA_PRE = 6'h10,
		DBCA_MRS = 6'h20
	} dbca_cmd_e;
	typedef struct packed {
		logic valid;
		logic wr;
		logic ap;
		logic [1:0] bank;
		logic [9:0] col;
	} dbca_slot_s;
	typedef logic [9:0] dbca_col_t;
endpackage

// *** core/dbca_burst_ord.sv ***
// Column offset of one burst beat from start address, length and type.
`timescale 1ns/100ps
`default_nettype none
module dbca_burst_ord (
	input wire logic [2:0] start,
	input wire logic [2:0] beat,
	input wire logic bl8,
	input wire logic ilv,
	output logic [2:0] ofs
);
	// Sequential order wraps inside the nibble; the upper bit only flips for eight beats.
	wire [1:0] seq_lo = start[1:0] + beat[1:0];
	wire hi = bl8 ? (start[2] ^ beat[2]) : start[2];
	assign ofs = ilv ? {hi, start[1:0] ^ beat[1:0]} : {hi, seq_lo};
endmodule
`default_nettype wire

// *** core/dbca_top.sv ***
// Column burst access logic of a four bank DDR2 device with an AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "dbca_map.svh"
module dbca_top (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic ck,
	input wire logic cs_b,
	input wire logic ras_b,
	input wire logic cas_b,
	input wire logic we_b,
	input wire logic [1:0] ba,
	input wire logic [12:0] addr,
	input wire logic [15:0] dq_i,
	output logic [15:0] dq_o,
	output logic dq_oe_b,
	input wire logic dqs_i,
	output logic dqs_o,
	output logic dqs_oe_b,
	input wire logic [1:0] dm,
	output logic [1:0] arr_rd_bank,
	output dbca_pkg::dbca_col_t arr_rd_col,
	input wire logic [15:0] arr_rd_data,
	output logic arr_we,
	output logic [1:0] arr_wr_bank,
	output dbca_pkg::dbca_col_t arr_wr_col,
	output logic [15:0] arr_wr_data,
	output logic [1:0] arr_wr_lane_en,
	output logic pre_ok,
	output logic wr_recov_start
);
	import dbca_pkg::*;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [38:0] pin1_q, pin2_q;
	logic ck_s, cs_s, ras_s, cas_s, we_s, dqs_s;
	logic [1:0] ba_s, dm_s;
	logic [12:0] addr_s;
	logic [15:0] dq_s;
	logic ck_prev_q, dqs_prev_q;

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			pin1_q <= `DBCA_PIN_RST;
			pin2_q <= `DBCA_PIN_RST;
			ck_prev_q <= 1'b1;
			dqs_prev_q <= 1'b0;
		end else if (ce) begin
			pin1_q <= {ck, cs_b, ras_b, cas_b, we_b, ba, addr, dq_i, dqs_i, dm};
			pin2_q <= pin1_q;
			ck_prev_q <= ck_s;
			dqs_prev_q <= dqs_s;
		end
	end
	assign {ck_s, cs_s, ras_s, cas_s, we_s, ba_s, addr_s, dq_s, dqs_s, dm_s} = pin2_q;

	wire tick_r = ck_s & ~ck_prev_q;
	wire tick_f = ~ck_s & ck_prev_q;
	wire ck_edge = tick_r | tick_f;
	wire dqs_r = dqs_s & ~dqs_prev_q;
	wire dqs_f = ~dqs_s & dqs_prev_q;

	// ----------------------------------------
	// Command decode and mode fields
	// ----------------------------------------
	// Code 110 is burst terminate on older parts and is taken as no operation here.
	dbca_cmd_e cmd;
	assign cmd = cs_s ? DBCA_NOP :
		({ras_s, cas_s, we_s} == 3'h3) ? DBCA_ACT :
		({ras_s, cas_s, we_s} == 3'h5) ? DBCA_RD :
		({ras_s, cas_s, we_s} == 3'h4) ? DBCA_WR :
		({ras_s, cas_s, we_s} == 3'h2) ? DBCA_PRE :
		({ras_s, cas_s, we_s} == 3'h0) ? DBCA_MRS : DBCA_NOP;

	logic [7:0] mode_q, emr_q;
	wire [2:0] bl_code = mode_q[`DBCA_BL_MSB:`DBCA_BL_LSB];
	wire ilv = mode_q[`DBCA_BT_BIT];
	wire [2:0] cl = mode_q[`DBCA_CL_MSB:`DBCA_CL_LSB];
	wire [2:0] al = emr_q[`DBCA_AL_MSB:`DBCA_AL_LSB];
	wire bl8 = (bl_code == `DBCA_BL8_CODE);
	wire bl_ok = bl8 | (bl_code == `DBCA_BL4_CODE);
	wire [3:0] half = bl8 ? `DBCA_HALF_BL8 : `DBCA_HALF_BL4;
	wire [2:0] last = bl8 ? `DBCA_LAST_BL8 : `DBCA_LAST_BL4;
	wire [3:0] rl = {1'b0, al} + {1'b0, cl};
	wire col_cmd = (cmd == DBCA_RD) | (cmd == DBCA_WR);
	wire a10 = addr_s[`DBCA_A10_BIT];

	// ----------------------------------------
	// Latency line, one slot per link clock
	// ----------------------------------------
	// Slot i holds the column command issued i+1 clocks ago; taps pick the ages that matter.
	dbca_slot_s line_q [0:15];
	dbca_slot_s slot_now;
	assign slot_now = '{valid: col_cmd & bl_ok, wr: (cmd == DBCA_WR), ap: a10, bank: ba_s, col: addr_s[9:0]};

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			for (int i = 0; i < 16; i++) begin
				line_q[i] <= '0;
			end
		end else if (ce && tick_r) begin
			line_q[0] <= slot_now;
			for (int i = 1; i < 16; i++) begin
				line_q[i] <= line_q[i-1];
			end
		end
	end

	wire [3:0] idx_rd = rl - 4'h1;
	wire [3:0] idx_wr = rl - 4'h2;
	wire [3:0] idx_rp = {1'b0, al} + half - 4'h1;
	wire [3:0] idx_wrr = rl + half - 4'h2;
	dbca_slot_s s_rd, s_wr, s_rp, s_wrr;
	assign s_rd = line_q[idx_rd];
	assign s_wr = line_q[idx_wr];
	assign s_rp = line_q[idx_rp];
	assign s_wrr = line_q[idx_wrr];
	wire rd_start = tick_r & s_rd.valid & ~s_rd.wr;
	wire pre_amb = tick_r & s_wr.valid & ~s_wr.wr;
	wire wr_open = tick_r & s_wr.valid & s_wr.wr;
	wire pre_ok_d = tick_r & s_rp.valid & ~s_rp.wr;
	wire wr_recov_d = tick_r & s_wrr.valid & s_wrr.wr;

	// ----------------------------------------
	// Read burst engine
	// ----------------------------------------
	logic rd_active_q, rd_load_q;
	logic [2:0] rd_beat_q;
	logic [1:0] rd_bank_q;
	dbca_col_t rd_col_q;
	// A new start restarts the beat count, which covers seamless and two clock interrupts alike.
	wire rd_end = rd_active_q & ck_edge & (rd_beat_q == last) & ~rd_start;
	wire rd_adv = rd_active_q & ck_edge & (rd_beat_q != last) & ~rd_start;
	wire rd_step = rd_start | rd_adv;
	wire [2:0] rd_beat_d = rd_start ? 3'h0 : rd_beat_q + 3'h1;
	dbca_col_t rd_scol_d;
	assign rd_scol_d = rd_start ? s_rd.col : rd_col_q;
	wire [1:0] rd_bank_d = rd_start ? s_rd.bank : rd_bank_q;
	wire [2:0] rd_ofs;
	dbca_burst_ord u_rd_ord (
		.start(rd_scol_d[2:0]),
		.beat(rd_beat_d),
		.bl8(bl8),
		.ilv(ilv),
		.ofs(rd_ofs)
	);
	dbca_col_t rd_acol_d;
	assign rd_acol_d = bl8 ? {rd_scol_d[9:3], rd_ofs} : {rd_scol_d[9:2], rd_ofs[1:0]};

	logic [15:0] dq_o_q;
	logic dq_oe_b_q, dqs_o_q, dqs_oe_b_q;
	logic [1:0] arr_rd_bank_q;
	dbca_col_t arr_rd_col_q;

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			rd_active_q <= 1'b0;
			rd_load_q <= 1'b0;
			rd_beat_q <= 3'h0;
			rd_bank_q <= 2'h0;
			rd_col_q <= '0;
			arr_rd_bank_q <= 2'h0;
			arr_rd_col_q <= '0;
		end else if (ce) begin
			rd_load_q <= rd_step;
			if (rd_step) begin
				rd_active_q <= 1'b1;
				rd_beat_q <= rd_beat_d;
				rd_col_q <= rd_scol_d;
				rd_bank_q <= rd_bank_d;
				arr_rd_bank_q <= rd_bank_d;
				arr_rd_col_q <= rd_acol_d;
			end else if (rd_end) begin
				rd_active_q <= 1'b0;
			end
		end
	end

	// The array answers in the cycle its address stands, so data and strobe follow one cycle later.
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			dq_o_q <= 16'h0000;
			dq_oe_b_q <= 1'b1;
			dqs_o_q <= 1'b0;
			dqs_oe_b_q <= 1'b1;
		end else if (ce) begin
			if (rd_load_q) begin
				dq_o_q <= arr_rd_data;
				dqs_o_q <= ~rd_beat_q[0];
			end
			if (rd_start) begin
				dq_oe_b_q <= 1'b0;
			end else if (rd_end) begin
				dq_oe_b_q <= 1'b1;
				dqs_oe_b_q <= 1'b1;
			end
			// A burst that ends on the preamble tick still hands the strobe to the next one.
			if (pre_amb && (!rd_active_q || rd_end)) begin
				dqs_oe_b_q <= 1'b0;
				dqs_o_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Write capture engine
	// ----------------------------------------
	logic wr_active_q, wr_armed_q;
	logic [2:0] wr_beat_q;
	logic [1:0] wr_bank_q;
	dbca_col_t wr_col_q;
	// The first beat needs a rising strobe after the preamble; later beats take either edge.
	wire wr_go = wr_open | wr_active_q;
	wire wr_arm_eff = wr_open | wr_armed_q;
	wire [2:0] wr_beat_eff = wr_open ? 3'h0 : wr_beat_q;
	dbca_col_t wr_scol;
	assign wr_scol = wr_open ? s_wr.col : wr_col_q;
	wire [1:0] wr_sbank = wr_open ? s_wr.bank : wr_bank_q;
	wire cap = wr_go & (wr_arm_eff ? dqs_r : (dqs_r | dqs_f));
	wire wr_done = cap & (wr_beat_eff == last);
	wire [2:0] wr_ofs;
	dbca_burst_ord u_wr_ord (
		.start(wr_scol[2:0]),
		.beat(wr_beat_eff),
		.bl8(bl8),
		.ilv(ilv),
		.ofs(wr_ofs)
	);
	dbca_col_t wr_acol;
	assign wr_acol = bl8 ? {wr_scol[9:3], wr_ofs} : {wr_scol[9:2], wr_ofs[1:0]};

	logic arr_we_q;
	logic [1:0] arr_wr_bank_q, arr_wr_lane_en_q;
	dbca_col_t arr_wr_col_q;
	logic [15:0] arr_wr_data_q;

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			wr_active_q <= 1'b0;
			wr_armed_q <= 1'b0;
			wr_beat_q <= 3'h0;
			wr_bank_q <= 2'h0;
			wr_col_q <= '0;
		end else if (ce) begin
			if (wr_open) begin
				wr_col_q <= s_wr.col;
				wr_bank_q <= s_wr.bank;
			end
			if (wr_done) begin
				wr_active_q <= 1'b0;
				wr_armed_q <= 1'b0;
			end else if (cap) begin
				wr_active_q <= 1'b1;
				wr_armed_q <= 1'b0;
				wr_beat_q <= wr_beat_eff + 3'h1;
			end else if (wr_open) begin
				wr_active_q <= 1'b1;
				wr_armed_q <= 1'b1;
				wr_beat_q <= 3'h0;
			end
		end
	end

	// Mask bits only reach the array through this write path, never the read path.
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			arr_we_q <= 1'b0;
			arr_wr_bank_q <= 2'h0;
			arr_wr_col_q <= '0;
			arr_wr_data_q <= 16'h0000;
			arr_wr_lane_en_q <= 2'h0;
		end else if (ce) begin
			arr_we_q <= cap;
			if (cap) begin
				arr_wr_bank_q <= wr_sbank;
				arr_wr_col_q <= wr_acol;
				arr_wr_data_q <= dq_s;
				arr_wr_lane_en_q <= ~dm_s;
			end
		end
	end

	// ----------------------------------------
	// Bank state and timing events
	// ----------------------------------------
	logic [3:0] open_q;
	logic pre_ok_q, wr_recov_q;
	wire [3:0] ba_mask = 4'h1 << ba_s;
	wire [3:0] act_set = (tick_r && cmd == DBCA_ACT) ? ba_mask : 4'h0;
	wire [3:0] pre_clr = (tick_r && cmd == DBCA_PRE) ? (a10 ? 4'hF : ba_mask) : 4'h0;
	wire [3:0] ap_clr = ((pre_ok_d && s_rp.ap) ? (4'h1 << s_rp.bank) : 4'h0) |
		((wr_recov_d && s_wrr.ap) ? (4'h1 << s_wrr.bank) : 4'h0);
	wire [3:0] open_d = (open_q & ~(pre_clr | ap_clr)) | act_set;

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			open_q <= 4'h0;
			pre_ok_q <= 1'b0;
			wr_recov_q <= 1'b0;
		end else if (ce) begin
			open_q <= open_d;
			pre_ok_q <= pre_ok_d;
			wr_recov_q <= wr_recov_d;
		end
	end

	// ----------------------------------------
	// AXI4-Lite register slave
	// ----------------------------------------
	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q, aw_got_q, w_got_q;
	logic [1:0] bresp_q, rresp_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q, rdata_q;
	logic [3:0] wstrb_q;
	wire aw_hs = s_axi_awvalid & awready_q;
	wire w_hs = s_axi_wvalid & wready_q;
	wire do_wr = aw_got_q & w_got_q & ~bvalid_q;
	wire wr_hit = (awaddr_q == `DBCA_OFS_MODE) | (awaddr_q == `DBCA_OFS_EMR) | (awaddr_q == `DBCA_OFS_STAT);
	wire sw_mode = do_wr & wstrb_q[0] & (awaddr_q == `DBCA_OFS_MODE);
	wire sw_emr = do_wr & wstrb_q[0] & (awaddr_q == `DBCA_OFS_EMR);
	wire pin_mr = tick_r & (cmd == DBCA_MRS) & (ba_s == `DBCA_BA_MR);
	wire pin_emr = tick_r & (cmd == DBCA_MRS) & (ba_s == `DBCA_BA_EMR);
	wire [7:0] mode_d = pin_mr ? addr_s[7:0] : sw_mode ? wdata_q[7:0] : mode_q;
	wire [7:0] emr_d = pin_emr ? addr_s[7:0] : sw_emr ? wdata_q[7:0] : emr_q;
	wire [31:0] stat = {`DBCA_STAT_PAD, ~bl_ok, wr_active_q, rd_active_q, open_q};
	wire ar_mode = (s_axi_araddr == `DBCA_OFS_MODE);
	wire ar_emr = (s_axi_araddr == `DBCA_OFS_EMR);
	wire ar_stat = (s_axi_araddr == `DBCA_OFS_STAT);
	wire [31:0] rd_mux = ar_mode ? {24'h0, mode_q} : ar_emr ? {24'h0, emr_q} : ar_stat ? stat : 32'h0;
	wire ar_hs = s_axi_arvalid & arready_q;

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			mode_q <= `DBCA_MODE_RST;
			emr_q <= `DBCA_EMR_RST;
		end else if (ce) begin
			mode_q <= mode_d;
			emr_q <= emr_d;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= `DBCA_RESP_OKAY;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
		end else if (ce) begin
			if (aw_hs) begin
				aw_got_q <= 1'b1;
				awready_q <= 1'b0;
				awaddr_q <= s_axi_awaddr;
			end
			if (w_hs) begin
				w_got_q <= 1'b1;
				wready_q <= 1'b0;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (do_wr) begin
				aw_got_q <= 1'b0;
				w_got_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_hit ? `DBCA_RESP_OKAY : `DBCA_RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
				awready_q <= 1'b1;
				wready_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0;
			rresp_q <= `DBCA_RESP_OKAY;
		end else if (ce) begin
			if (ar_hs) begin
				arready_q <= 1'b0;
				rvalid_q <= 1'b1;
				rdata_q <= rd_mux;
				rresp_q <= (ar_mode | ar_emr | ar_stat) ? `DBCA_RESP_OKAY : `DBCA_RESP_SLVERR;
			end else if (rvalid_q && s_axi_rready) begin
				rvalid_q <= 1'b0;
				arready_q <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign dq_o = dq_o_q;
	assign dq_oe_b = dq_oe_b_q;
	assign dqs_o = dqs_o_q;
	assign dqs_oe_b = dqs_oe_b_q;
	assign arr_rd_bank = arr_rd_bank_q;
	assign arr_rd_col = arr_rd_col_q;
	assign arr_we = arr_we_q;
	assign arr_wr_bank = arr_wr_bank_q;
	assign arr_wr_col = arr_wr_col_q;
	assign arr_wr_data = arr_wr_data_q;
	assign arr_wr_lane_en = arr_wr_lane_en_q;
	assign pre_ok = pre_ok_q;
	assign wr_recov_start = wr_recov_q;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b || !ce);

	sequence seq_rd_fetch;
		rd_load_q ##1 (!dq_oe_b_q && dqs_o_q);
	endsequence

	a_read_launch: assert property (rd_start |=> seq_rd_fetch) else $error("read burst did not launch");
	a_preamble_low: assert property ((pre_amb && (!rd_active_q || rd_end)) |=> (!dqs_oe_b_q && !dqs_o_q)) else $error("no preamble");
	a_order_ilv8: assert property ((bl8 && ilv) |-> rd_ofs == (rd_scol_d[2:0] ^ rd_beat_d)) else $error("bad interleave order");
	a_order_seq4: assert property ((!bl8 && !ilv) |-> rd_ofs[1:0] == 2'(rd_scol_d[1:0] + rd_beat_d[1:0])) else $error("bad order");
	a_order_seq8: assert property ((bl8 && !ilv) |-> rd_ofs[2] == (rd_scol_d[2] ^ rd_beat_d[2])) else $error("bad nibble order");
	a_bl_legal: assert property ((tick_r && col_cmd && !bl_ok) |=> !line_q[0].valid) else $error("illegal length accepted");
	a_write_stop: assert property ((wr_done && !wr_open) |=> (!wr_active_q && arr_we_q)) else $error("write ran past length");
	a_mask_lane: assert property (cap |=> (arr_we_q && arr_wr_lane_en_q == ~$past(dm_s))) else $error("mask not applied");
	a_prech_all: assert property ((tick_r && cmd == DBCA_PRE && a10) |=> open_q == 4'h0) else $error("banks left open");
	a_prech_bank: assert property ((tick_r && cmd == DBCA_PRE && !a10) |=> !open_q[$past(ba_s)]) else $error("bank left open");
endmodule
`default_nettype wire

// *** testbench/dbca_ctrl_model.sv ***
// Behavioural memory controller that drives the link pins of the burst block.
`timescale 1ns/100ps
`default_nettype none
module dbca_ctrl_model (
	output logic ck,
	output logic cs_b,
	output logic ras_b,
	output logic cas_b,
	output logic we_b,
	output logic [1:0] ba,
	output logic [12:0] addr,
	output logic [15:0] dq_i,
	output logic dqs_i,
	output logic [1:0] dm
);
	realtime t_cmd;
	// ----------------------------------------
	// Link clock and commands
	// ----------------------------------------
	initial begin
		{cs_b, ras_b, cas_b, we_b} = 4'hF;
		{ck, ba, addr, dq_i, dqs_i, dm} = '0;
		#7;
		forever #80 ck = ~ck;
	end
	// Pins change on the falling edge and stand a full half cycle past the rise.
	// Back-to-back calls therefore land exactly two link clocks apart.
	task automatic cmd(input logic [2:0] rcw, input logic [1:0] b, input logic [12:0] a);
		@(negedge ck);
		cs_b = 1'b0;
		{ras_b, cas_b, we_b} = rcw;
		ba = b;
		addr = a;
		@(posedge ck);
		t_cmd = $realtime;
		@(negedge ck);
		cs_b = 1'b1;
		{ras_b, cas_b, we_b} = ~rcw;
		addr = ~a;
	endtask
	// Strobe edges trail the link edges by an eighth of a clock; data is centred on them.
	task automatic wburst(input int wl, input int n, input logic [15:0] base, input logic [15:0] dmp);
		repeat (wl - 1) @(posedge ck);
		@(negedge ck);
		#20;
		for (int k = 0; k < n; k++) begin
			#40;
			dq_i = base + 16'(k);
			dm = dmp[2*k +: 2];
			#40;
			dqs_i = ~dqs_i;
		end
	endtask
endmodule
`default_nettype wire

// *** testbench/test_ddr2_burst_column_access.sv ***
// Self-checking bench for the burst column access block.
`timescale 1ns/100ps
`default_nettype none
module test_ddr2_burst_column_access;
	import dbca_pkg::*;
	logic sys_clk, rst_b, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, ba, dm, arr_rd_bank, arr_wr_bank, arr_wr_lane_en;
	logic ck, cs_b, ras_b, cas_b, we_b, dq_oe_b, dqs_i, dqs_o, dqs_oe_b, arr_we, pre_ok, wr_recov_start;
	logic [12:0] addr;
	logic [15:0] dq_i, dq_o, arr_wr_data;
	dbca_col_t arr_rd_col, arr_wr_col;
	wire [15:0] arr_rd_data = {4'h0, arr_rd_bank, arr_rd_col};
	int bad_count, tests_run;
	logic dqs_prev = 1'b0;
	logic [15:0] rq[$];
	logic [29:0] wq[$];
	realtime rt[$], pq[$], wrq[$];
	realtime t_pre;
	dbca_top uut (.sys_clk, .rst_b, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .ck, .cs_b, .ras_b, .cas_b, .we_b, .ba, .addr, .dq_i, .dq_o, .dq_oe_b, .dqs_i,
		.dqs_o, .dqs_oe_b, .dm, .arr_rd_bank, .arr_rd_col, .arr_rd_data, .arr_we, .arr_wr_bank,
		.arr_wr_col, .arr_wr_data, .arr_wr_lane_en, .pre_ok, .wr_recov_start);
	dbca_ctrl_model ctrl (.ck, .cs_b, .ras_b, .cas_b, .we_b, .ba, .addr, .dq_i, .dqs_i, .dm);
	// ----------------------------------------
	// Clock, monitors and helpers
	// ----------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		if (dq_oe_b === 1'b0 && dqs_o !== dqs_prev) begin
			rq.push_back(dq_o);
			rt.push_back($realtime);
		end
		if (arr_we === 1'b1) wq.push_back({arr_wr_bank, arr_wr_col, arr_wr_data, arr_wr_lane_en});
		if (pre_ok === 1'b1) pq.push_back($realtime);
		if (wr_recov_start === 1'b1) wrq.push_back($realtime);
		dqs_prev <= dqs_o;
	end
	always @(negedge dqs_oe_b) t_pre = $realtime;
	task automatic give_verdict;
		if (bad_count == 0 && tests_run > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH at %0t: saw %h, expected %h", $realtime, seen, exp);
		end
	endtask
	task automatic hang;
		bad_count++;
		$display("MISMATCH at %0t: wait ran out", $realtime);
		give_verdict;
	endtask
	// Sync delays make link timings jitter by a few system cycles, hence a window.
	function automatic logic near(input realtime d, input realtime nom);
		return d >= nom + 40 && d <= nom + 160;
	endfunction
	task automatic wait_q(input int w, input int n);
		int i;
		for (i = 0; i < 2000; i++) begin
			if ((w == 0 ? rq.size() : w == 1 ? wq.size() : w == 2 ? pq.size() : wrq.size()) >= n) break;
			@(posedge sys_clk);
		end
		if (i == 2000) hang;
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge sys_clk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) break;
		end
		if (n == 40) hang;
		check(s_axi_bresp, er);
		s_axi_bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge sys_clk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) break;
		end
		if (n == 40) hang;
		check(s_axi_rdata, ed);
		check(s_axi_rresp, er);
		s_axi_rready <= 1'b0;
	endtask
	task automatic set_mode(input logic [2:0] bl, input logic ilv, input logic [2:0] al);
		ctrl.cmd(3'h0, 2'h0, {5'h0, 1'b0, 3'h3, ilv, bl});
		axi_wr(8'h04, {26'h0, al, 3'h0}, 2'h0);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_read(input logic [1:0] b, input logic [2:0] s, input logic bl8, input logic ilv, input int al);
		logic [9:0] c;
		logic [2:0] kk, o;
		c = {7'h55, s};
		rq.delete();
		rt.delete();
		ctrl.cmd(3'h5, b, {3'h0, c});
		wait_q(0, bl8 ? 8 : 4);
		for (int k = 0; k < (bl8 ? 8 : 4); k++) begin
			kk = 3'(k);
			o = ilv ? s ^ kk : {s[2] ^ kk[2], 2'(s[1:0] + kk[1:0])};
			if (!bl8) o[2] = s[2];
			check(rq[k], {4'h0, b, c[9:3], o});
		end
		check(near(rt[0] - ctrl.t_cmd, (al + 3) * 160), 1);
		check(rt[0] - t_pre > 120 && rt[0] - t_pre < 260, 1);
	endtask
	task automatic t_rd_intr;
		realtime t1;
		logic [2:0] kk, s, o;
		set_mode(3'h3, 1'b0, 3'h0);
		ctrl.cmd(3'h3, 2'h0, 13'h0);
		ctrl.cmd(3'h3, 2'h1, 13'h0);
		rq.delete();
		rt.delete();
		pq.delete();
		ctrl.cmd(3'h5, 2'h0, 13'h005);
		t1 = ctrl.t_cmd;
		ctrl.cmd(3'h5, 2'h1, 13'h402);
		wait_q(0, 12);
		for (int k = 0; k < 12; k++) begin
			kk = 3'(k < 4 ? k : k - 4);
			s = k < 4 ? 3'h5 : 3'h2;
			o = {s[2] ^ kk[2], 2'(s[1:0] + kk[1:0])};
			check(rq[k], {4'h0, k < 4 ? 2'h0 : 2'h1, 7'h0, o});
			if (k > 0) check(rt[k] - rt[k-1] < 100, 1);
		end
		wait_q(2, 2);
		check(near(pq[0] - t1, 640) && near(pq[1] - t1, 960), 1);
		// The second burst is still winding down; let the read-active flag settle first.
		repeat (10) @(posedge sys_clk);
		axi_rd(8'h08, 32'h1, 2'h0);
	endtask
	task automatic t_write;
		realtime t1;
		logic [15:0] m;
		m = 16'h00E4;
		set_mode(3'h2, 1'b0, 3'h0);
		wq.delete();
		wrq.delete();
		ctrl.cmd(3'h4, 2'h2, 13'h031);
		t1 = ctrl.t_cmd;
		ctrl.wburst(2, 6, 16'hC000, m);
		repeat (20) @(posedge sys_clk);
		check(wq.size(), 4);
		for (int k = 0; k < 4; k++) check(wq[k], {2'h2, 8'h0C, 2'(k + 1), 16'hC000 + 16'(k), ~m[2*k +: 2]});
		wait_q(3, 1);
		check(near(wrq[0] - t1, 640), 1);
		set_mode(3'h3, 1'b1, 3'h0);
		wq.delete();
		wrq.delete();
		ctrl.cmd(3'h4, 2'h3, 13'h006);
		t1 = ctrl.t_cmd;
		fork
			ctrl.wburst(2, 4, 16'hA000, 16'h0);
		join_none
		ctrl.cmd(3'h4, 2'h0, 13'h000);
		ctrl.wburst(2, 8, 16'hB000, 16'h0);
		wait_q(1, 12);
		for (int k = 0; k < 12; k++) begin
			check(wq[k], {k < 4 ? 2'h3 : 2'h0, 7'h0, (k < 4 ? 3'h6 : 3'h0) ^ 3'(k < 4 ? k : k - 4),
				(k < 4 ? 16'hA000 : 16'hAFFC) + 16'(k), 2'h3});
		end
		wait_q(3, 2);
		check(near(wrq[0] - t1, 960) && near(wrq[1] - t1, 1280), 1);
	endtask
	task automatic t_precharge;
		for (int i = 0; i < 4; i++) ctrl.cmd(3'h3, 2'(i), 13'h0);
		axi_rd(8'h08, 32'h0F, 2'h0);
		ctrl.cmd(3'h2, 2'h2, 13'h0);
		axi_rd(8'h08, 32'h0B, 2'h0);
		ctrl.cmd(3'h2, 2'h1, 13'h400);
		axi_rd(8'h08, 32'h00, 2'h0);
		ctrl.cmd(3'h0, 2'h0, 13'h031);
		axi_rd(8'h08, 32'h40, 2'h0);
		axi_rd(8'h00, 32'h31, 2'h0);
		rq.delete();
		ctrl.cmd(3'h5, 2'h0, 13'h0);
		repeat (100) @(posedge sys_clk);
		check(rq.size(), 0);
	endtask
	initial begin
		bad_count = 0;
		tests_run = 0;
		ce = 1'b1;
		rst_b = 1'b0;
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
		repeat (5) @(posedge sys_clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge sys_clk);
		axi_rd(8'h00, 32'h32, 2'h0);
		axi_rd(8'h04, 32'h0, 2'h0);
		axi_rd(8'h0C, 32'h0, 2'h2);
		axi_wr(8'h0C, 32'hFF, 2'h2);
		axi_wr(8'h08, 32'hFF, 2'h0);
		axi_rd(8'h08, 32'h0, 2'h0);
		// Clock enable low freezes the link path, so this mode command must be lost.
		ce <= 1'b0;
		ctrl.cmd(3'h0, 2'h0, 13'h033);
		@(posedge sys_clk);
		ce <= 1'b1;
		axi_rd(8'h00, 32'h32, 2'h0);
		ctrl.dm <= 2'h3;
		// Mask held high through all reads; it must not disturb read data.
		for (int m = 0; m < 4; m++) begin
			set_mode(m[1] ? 3'h3 : 3'h2, m[0], m[0] ? 3'h2 : 3'h0);
			for (int s = 0; s < (m[1] ? 8 : 4); s++) t_read(2'(s), 3'(m[1] ? s : s + 4), m[1], m[0], m[0] ? 2 : 0);
		end
		t_rd_intr;
		t_write;
		t_precharge;
		give_verdict;
	end
endmodule
`default_nettype wire
